// file: bench/csf_channel_asserts.sv
// port checker of the channel block, bus timing and value pulse relations
// assumes hready is tied to hreadyout
`timescale 1ns/1ps
module csf_chk #(parameter int DW = 32) (
    // clock, reset and bus
    input wire logic          sys_clk, nrst, hsel, hwrite, hready, hreadyout, hresp,
    input wire logic [31:0]   haddr, hwdata, hrdata,
    input wire logic [1:0]    htrans,
    input wire logic [2:0]    hsize,
    // samples
    input wire logic [DW-1:0] sample_in, reset_chan_in, value_out,
    input wire logic          value_valid
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    wire tk = hsel && hready && htrans[1];
    a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
    a_write_wait: assert property (tk && hwrite |=> !hreadyout ##1 hreadyout)
        else $error("write wait state wrong");
    a_read_nowait: assert property (tk && !hwrite |=> hreadyout) else $error("read stalled");
    a_unmapped_zero: assert property (tk && !hwrite && haddr[31:8] != 0 |=> hrdata == 0)
        else $error("unmapped read not zero");
    a_value_read: assert property (tk && !hwrite && haddr == 32'h48 |=>
        hrdata == $past(value_out)) else $error("value register wrong");
    a_valid_pulse: assert property (value_valid |=> !value_valid) else $error("long pulse");
    a_value_hold: assert property ($changed(value_out) |-> value_valid)
        else $error("value changed without pulse");
    a_one_per_tick: assert property ($rose(value_valid) |-> ##1 (!value_valid)[*8])
        else $error("values too close");
endmodule
bind csf_channel csf_chk #(.DW(DW)) chk_u (.sys_clk, .nrst, .hsel, .hwrite, .hready,
    .hreadyout, .hresp, .haddr, .hwdata, .hrdata, .htrans, .hsize, .sample_in,
    .reset_chan_in, .value_out, .value_valid);

// file: bench/csf_src.sv
// channel source model: presents the source sample and reset channel levels
// assumes the bench sets the wanted levels right after a rising edge
`timescale 1ns/1ps
module csf_src (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // wanted levels
    input  wire logic [31:0] smp,
    input  wire logic [31:0] rch,
    // levels seen by the channel
    output      logic [31:0] sample_in,
    output      logic [31:0] reset_chan_in
);
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sample_in     <= 32'h0;
            reset_chan_in <= 32'h0;
        end else begin
            sample_in     <= smp;
            reset_chan_in <= rch;
        end
    end
endmodule

// file: bench/tb_channel_scale_and_filter.sv
// self-checking bench of the channel block over ahb-lite
// assumes a short tick of 100 cycles
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_channel_scale_and_filter import csf_pkg::*;;
    logic        sys_clk = 0, nrst = 0, hsel = 0, hwrite = 0, ok;
    logic [31:0] haddr = 0, hwdata = 0, smp = 0, rch = 0, rd, x, ad;
    logic [31:0] hrdata, value_out, sample_in, reset_chan_in;
    logic [1:0]  htrans = 0;
    logic        hreadyout, hresp, value_valid;
    int          err_total = 0, checks = 0, cyc = 0, seed = 75, n;
    initial forever #4 sys_clk = ~sys_clk;
    csf_channel #(.TICK_CYCLES(100)) dut_u (.sys_clk, .nrst, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .sample_in, .reset_chan_in, .value_out, .value_valid);
    csf_src src_u (.sys_clk, .nrst, .smp, .rch, .sample_in, .reset_chan_in);
    task give_verdict;
        if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task hwait;
        do begin
            @(negedge sys_clk);
            ok = hreadyout;
            rd = hrdata;
            @(posedge sys_clk);
        end while (ok !== 1'b1);
    endtask
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        hwait;
        htrans <= 2'h0;
        hwdata <= d;
        hwait;
    endtask
    task nextval;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (value_valid !== 1'b1 && n < 400);
        `CHK(value_valid, 1'b1)
        @(posedge sys_clk);
    endtask
    task run(input logic [31:0] s, input logic [31:0] e);
        nextval;
        smp <= s;
        nextval;
        `CHK(value_out, e)
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            give_verdict;
        end
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        nrst <= 1;
        @(posedge sys_clk);
        xfer(0, 32'h100, 0);
        `CHK(rd, 32'h0)
        ad = $random(seed) & 32'hffff;
        xfer(1, CSF_A_LIN_Y2, 32'h20000);
        xfer(1, CSF_A_ADDEND, ad);
        for (int i = 0; i < 4; i++) begin
            x = (i == 0) ? 32'hffff8000 : (i == 1) ? 32'h30000 : $random(seed) & 32'h7fff;
            xfer(1, CSF_A_CTRL, 32'h0);
            run(x, x);
            xfer(1, CSF_A_CTRL, 32'h2);
            run(x, x + ad);
            xfer(1, CSF_A_CTRL, 32'h5);
            run(x, x << 1);
            xfer(1, CSF_A_CTRL, 32'h7);
            run(x, x);
        end
        xfer(0, CSF_A_VALUE, 0);
        `CHK(rd, x)
        xfer(1, CSF_A_CMD, 32'h1);
        xfer(0, CSF_A_STATUS, 0);
        `CHK(rd[9:0], 10'h23)
        xfer(1, CSF_A_CMD, 32'h2);
        xfer(1, CSF_A_CMD, 32'h2);
        xfer(0, CSF_A_STATUS, 0);
        `CHK(rd[4:0], CSF_CNT_RST)
        xfer(1, CSF_A_THR, 32'h10000);
        xfer(1, CSF_A_HOLD, 32'h8);
        xfer(1, CSF_A_CTRL, 32'h8);
        rch <= 32'h1;
        run(32'h70000, 32'h70000);
        run(32'h50000, 32'h70000);
        xfer(1, CSF_A_CTRL, 32'h28);
        run(32'h50000, 32'h50000);
        xfer(1, CSF_A_K, 32'h8000);
        xfer(1, CSF_A_CTRL, 32'h4);
        run(32'h40000, 32'h48000);
        xfer(1, CSF_A_CTRL, 32'h18);
        run(32'h60000, 32'h40000);
        xfer(1, CSF_A_TP_SEL, 32'h2);
        xfer(1, CSF_A_TP_X, 32'h20000);
        xfer(1, CSF_A_TP_Y, 32'h30000);
        xfer(1, CSF_A_TP_CNT, 32'h3);
        xfer(1, CSF_A_CMD, 32'h4);
        xfer(1, CSF_A_CTRL, 32'h3);
        run(32'h18000, 32'h20000);
        xfer(1, CSF_A_PT_SEL, 32'h2);
        xfer(1, CSF_A_PT_X, 32'h5678);
        xfer(0, CSF_A_TP_X, 0);
        `CHK(rd, 32'h20000)
        give_verdict;
    end
endmodule

// file: rtl/csf_channel.sv
// channel scale-and-filter: ahb-lite register slave plus sample pipeline
// assumes sample_in and reset_chan_in are levels held by the source, q16.16
//
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
import csf_pkg::*;

module csf_channel import csf_pkg::*; #(
    parameter int DW          = CSF_DW,
    parameter int FRAC        = CSF_FRAC,
    parameter int NPTS        = CSF_PT_MAX,
    parameter int TICK_CYCLES = CSF_TICK_CYCLES
) (
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          nrst,
    // ahb-lite slave
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output      logic          hreadyout,
    output      logic          hresp,
    output      logic [31:0]   hrdata,
    // channel samples
    input  wire logic [DW-1:0] sample_in,
    input  wire logic [DW-1:0] reset_chan_in,
    output      logic [DW-1:0] value_out,
    output      logic          value_valid
);
    // bus state
    logic              acc;
    logic              wr_reg;
    logic [7:0]        wa_reg;
    logic              ok_reg;
    logic              rdy_reg;
    logic [31:0]       rd_reg;
    logic [31:0]       rd_mux;
    logic              wr_ok;
    // configuration
    logic [5:0]        ctrl_reg;
    logic signed [DW-1:0] lx1_reg;
    logic signed [DW-1:0] ly1_reg;
    logic signed [DW-1:0] lx2_reg;
    logic signed [DW-1:0] ly2_reg;
    logic signed [DW-1:0] add_reg;
    logic signed [DW-1:0] k_reg;
    logic signed [DW-1:0] thr_reg;
    logic [DW-1:0]     hold_reg;
    // characteristic and template
    logic signed [DW-1:0] px [NPTS];
    logic signed [DW-1:0] py [NPTS];
    logic signed [DW-1:0] tx [NPTS];
    logic signed [DW-1:0] ty [NPTS];
    logic [4:0]        cnt_reg;
    logic [4:0]        sel_reg;
    logic [4:0]        tcnt_reg;
    logic [4:0]        tsel_reg;
    // pipeline
    csf_state_t        st_reg;
    csf_scale_t        smode;
    csf_filt_t         fmode;
    logic [31:0]       tk_reg;
    logic              tick_reg;
    logic [4:0]        seg;
    logic signed [DW-1:0] ax;
    logic signed [DW-1:0] ay;
    logic signed [DW-1:0] bx;
    logic signed [DW-1:0] by;
    logic              div_go;
    logic              div_done;
    logic [DW-1:0]     div_q;
    logic signed [DW-1:0] x_reg;
    logic signed [DW-1:0] rc_reg;
    logic signed [DW-1:0] ax_reg;
    logic signed [DW-1:0] ay_reg;
    logic signed [DW-1:0] slope_reg;
    logic signed [DW-1:0] s_reg;
    logic signed [DW-1:0] yp_reg;
    logic signed [DW-1:0] m1_p;
    logic signed [DW-1:0] m2_p;
    logic signed [DW-1:0] filt;
    // extremum detector
    logic signed [DW-1:0] trk_reg;
    logic              tv_reg;
    logic signed [DW-1:0] held_reg;
    logic [DW-1:0]     hc_reg;
    logic              ext_clr;
    logic              better;
    logic              found;
    logic [DW-1:0]     hc_now;
    logic signed [DW-1:0] held_now;
    logic signed [DW-1:0] pk_out;

    assign smode       = csf_scale_t'(ctrl_reg[CSF_CTRL_SCALE +: 2]);
    assign fmode       = csf_filt_t'(ctrl_reg[CSF_CTRL_FILT +: 2]);
    assign hreadyout   = rdy_reg;
    assign hresp       = 1'b0;
    assign hrdata      = rd_reg;

    // ahb-lite: reads answer at once, writes add one wait state
    assign acc   = hsel && hready && htrans[1];
    assign wr_ok = wr_reg && ok_reg;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_reg  <= 1'b0;
            wa_reg  <= 8'h00;
            ok_reg  <= 1'b0;
            rdy_reg <= 1'b1;
            rd_reg  <= 32'h0000_0000;
        end else begin
            wr_reg  <= acc && hwrite;
            rdy_reg <= !(acc && hwrite);
            if (acc) begin
                wa_reg <= haddr[7:0];
                ok_reg <= haddr[31:8] == 24'h00_0000;
            end
            if (acc && !hwrite) begin
                rd_reg <= (haddr[31:8] == 24'h00_0000) ? rd_mux : 32'h0000_0000;
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr[7:0])
            CSF_A_CTRL:   rd_mux = {26'h0, ctrl_reg};
            CSF_A_STATUS: begin
                rd_mux[4:0] = cnt_reg;
                rd_mux[CSF_ST_SEL +: 5] = sel_reg;
                rd_mux[CSF_ST_BUSY] = st_reg != ST_IDLE;
                rd_mux[CSF_ST_HELD] = hc_reg != '0;
            end
            CSF_A_LIN_X1: rd_mux = lx1_reg;
            CSF_A_LIN_Y1: rd_mux = ly1_reg;
            CSF_A_LIN_X2: rd_mux = lx2_reg;
            CSF_A_LIN_Y2: rd_mux = ly2_reg;
            CSF_A_ADDEND: rd_mux = add_reg;
            CSF_A_K:      rd_mux = k_reg;
            CSF_A_THR:    rd_mux = thr_reg;
            CSF_A_HOLD:   rd_mux = hold_reg;
            CSF_A_PT_SEL: rd_mux = {27'h0, sel_reg};
            CSF_A_PT_X:   rd_mux = px[sel_reg];
            CSF_A_PT_Y:   rd_mux = py[sel_reg];
            CSF_A_TP_SEL: rd_mux = {27'h0, tsel_reg};
            CSF_A_TP_X:   rd_mux = tx[tsel_reg];
            CSF_A_TP_Y:   rd_mux = ty[tsel_reg];
            CSF_A_TP_CNT: rd_mux = {27'h0, tcnt_reg};
            CSF_A_VALUE:  rd_mux = value_out;
            default:      rd_mux = 32'h0000_0000;
        endcase
    end

    // plain configuration registers
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= 6'h00;
            lx1_reg  <= CSF_ZERO_RST;
            ly1_reg  <= CSF_ZERO_RST;
            lx2_reg  <= CSF_ONE_RST;
            ly2_reg  <= CSF_ONE_RST;
            add_reg  <= CSF_ZERO_RST;
            k_reg    <= CSF_ZERO_RST;
            thr_reg  <= CSF_ZERO_RST;
            hold_reg <= CSF_ZERO_RST;
        end else if (wr_ok) begin
            case (wa_reg)
                CSF_A_CTRL:   ctrl_reg <= hwdata[5:0];
                CSF_A_LIN_X1: lx1_reg  <= hwdata;
                CSF_A_LIN_Y1: ly1_reg  <= hwdata;
                CSF_A_LIN_X2: lx2_reg  <= hwdata;
                CSF_A_LIN_Y2: ly2_reg  <= hwdata;
                CSF_A_ADDEND: add_reg  <= hwdata;
                CSF_A_K:      k_reg    <= hwdata;
                CSF_A_THR:    thr_reg  <= hwdata;
                CSF_A_HOLD:   hold_reg <= hwdata;
                default:      ctrl_reg <= ctrl_reg;
            endcase
        end
    end

    // channel characteristic: edit, add, delete, import
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NPTS; i++) begin
                px[i] <= (i == 1) ? CSF_ONE_RST : CSF_ZERO_RST;
                py[i] <= (i == 1) ? CSF_ONE_RST : CSF_ZERO_RST;
            end
            cnt_reg <= CSF_CNT_RST;
            sel_reg <= 5'h00;
        end else if (wr_ok) begin
            case (wa_reg)
                CSF_A_PT_SEL: begin
                    if (hwdata[4:0] < cnt_reg) begin
                        sel_reg <= hwdata[4:0];
                    end
                end
                CSF_A_PT_X: px[sel_reg] <= hwdata;
                CSF_A_PT_Y: py[sel_reg] <= hwdata;
                CSF_A_CMD: begin
                    if (hwdata[CSF_CMD_IMP]) begin
                        for (int i = 0; i < NPTS; i++) begin
                            px[i] <= tx[i];
                            py[i] <= ty[i];
                        end
                        cnt_reg <= tcnt_reg;
                        sel_reg <= 5'h00;
                    end else if (hwdata[CSF_CMD_ADD] && int'(cnt_reg) < NPTS) begin
                        for (int i = 1; i < NPTS; i++) begin
                            if (i > int'(sel_reg) && i <= int'(cnt_reg)) begin
                                px[i] <= px[i-1];
                                py[i] <= py[i-1];
                            end
                        end
                        cnt_reg <= cnt_reg + 5'h01;
                        sel_reg <= sel_reg + 5'h01;
                    end else if (hwdata[CSF_CMD_DEL] && int'(cnt_reg) > CSF_PT_MIN) begin
                        for (int i = 0; i < NPTS - 1; i++) begin
                            if (i >= int'(sel_reg) && i < int'(cnt_reg) - 1) begin
                                px[i] <= px[i+1];
                                py[i] <= py[i+1];
                            end
                        end
                        cnt_reg <= cnt_reg - 5'h01;
                        if (sel_reg == cnt_reg - 5'h01) begin
                            sel_reg <= sel_reg - 5'h01;
                        end
                    end
                end
                default: sel_reg <= sel_reg;
            endcase
        end
    end

    // stored template: edit and export
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NPTS; i++) begin
                tx[i] <= (i == 1) ? CSF_ONE_RST : CSF_ZERO_RST;
                ty[i] <= (i == 1) ? CSF_ONE_RST : CSF_ZERO_RST;
            end
            tcnt_reg <= CSF_CNT_RST;
            tsel_reg <= 5'h00;
        end else if (wr_ok) begin
            case (wa_reg)
                CSF_A_TP_SEL: begin
                    if (int'(hwdata[4:0]) < NPTS) begin
                        tsel_reg <= hwdata[4:0];
                    end
                end
                CSF_A_TP_X: tx[tsel_reg] <= hwdata;
                CSF_A_TP_Y: ty[tsel_reg] <= hwdata;
                CSF_A_TP_CNT: begin
                    if (hwdata[4:0] >= 5'(CSF_PT_MIN) && int'(hwdata[4:0]) <= NPTS) begin
                        tcnt_reg <= hwdata[4:0];
                    end
                end
                CSF_A_CMD: begin
                    if (hwdata[CSF_CMD_EXP] && !hwdata[CSF_CMD_IMP]) begin
                        for (int i = 0; i < NPTS; i++) begin
                            tx[i] <= px[i];
                            ty[i] <= py[i];
                        end
                        tcnt_reg <= cnt_reg;
                    end
                end
                default: tsel_reg <= tsel_reg;
            endcase
        end
    end

    // sample tick
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tk_reg   <= 32'h0000_0000;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= tk_reg == 32'(TICK_CYCLES - 1);
            tk_reg   <= (tk_reg == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000
                                                           : tk_reg + 32'h0000_0001;
        end
    end

    // segment whose right end is the first at or above the input
    always_comb begin
        seg = 5'h00;
        for (int i = 1; i < NPTS - 1; i++) begin
            if (i <= int'(cnt_reg) - 2 && $signed(sample_in) > px[i]) begin
                seg = 5'(i);
            end
        end
    end

    always_comb begin
        if (smode == SM_LIN) begin
            ax = lx1_reg;
            ay = ly1_reg;
            bx = lx2_reg;
            by = ly2_reg;
        end else begin
            ax = px[seg];
            ay = py[seg];
            bx = px[seg + 5'h01];
            by = py[seg + 5'h01];
        end
    end

    assign div_go = tick_reg && st_reg == ST_IDLE && (smode == SM_LIN || smode == SM_CHAR);

    csf_div #(.W(DW), .F(FRAC)) u_div (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .start   (div_go),
        .num     (by - ay),
        .den     (bx - ax),
        .done    (div_done),
        .quot    (div_q)
    );

    csf_mul #(.W(DW), .F(FRAC)) u_mscale (
        .a (slope_reg),
        .b (x_reg - ax_reg),
        .p (m1_p)
    );

    csf_mul #(.W(DW), .F(FRAC)) u_msmooth (
        .a (k_reg),
        .b (yp_reg - s_reg),
        .p (m2_p)
    );

    // extremum detector decision for the current scaled sample
    always_comb begin
        ext_clr  = ctrl_reg[CSF_CTRL_EXTR] && rc_reg > 0;
        better   = ctrl_reg[CSF_CTRL_VALLY] ? s_reg < trk_reg : s_reg > trk_reg;
        found    = 1'b0;
        if (!ext_clr && tv_reg && !better) begin
            found = ctrl_reg[CSF_CTRL_VALLY] ? s_reg - trk_reg >= thr_reg
                                             : trk_reg - s_reg >= thr_reg;
        end
        hc_now   = found ? hold_reg : (ext_clr ? '0 : hc_reg);
        held_now = found ? trk_reg : held_reg;
        pk_out   = (hc_now != '0) ? held_now : s_reg;
    end

    always_comb begin
        case (fmode)
            FM_SMOOTH: filt = (k_reg == '0) ? s_reg : s_reg + m2_p;
            FM_PEAK:   filt = pk_out;
            default:   filt = s_reg;
        endcase
    end

    // one pass per tick: capture, slope, scale, filter
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg    <= ST_IDLE;
            x_reg     <= CSF_ZERO_RST;
            rc_reg    <= CSF_ZERO_RST;
            ax_reg    <= CSF_ZERO_RST;
            ay_reg    <= CSF_ZERO_RST;
            slope_reg <= CSF_ZERO_RST;
            s_reg     <= CSF_ZERO_RST;
        end else begin
            case (st_reg)
                ST_IDLE: begin
                    if (tick_reg) begin
                        x_reg  <= sample_in;
                        rc_reg <= reset_chan_in;
                        ax_reg <= ax;
                        ay_reg <= ay;
                        st_reg <= div_go ? ST_DIV : ST_SCALE;
                    end
                end
                ST_DIV: begin
                    if (div_done) begin
                        slope_reg <= div_q;
                        st_reg    <= ST_SCALE;
                    end
                end
                ST_SCALE: begin
                    case (smode)
                        SM_OFF:  s_reg <= x_reg + add_reg;
                        SM_LIN,
                        SM_CHAR: s_reg <= ay_reg + m1_p;
                        default: s_reg <= x_reg;
                    endcase
                    st_reg <= ST_FILT;
                end
                ST_FILT: st_reg <= ST_IDLE;
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    // filter state and result
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            yp_reg      <= CSF_ZERO_RST;
            trk_reg     <= CSF_ZERO_RST;
            tv_reg      <= 1'b0;
            held_reg    <= CSF_ZERO_RST;
            hc_reg      <= CSF_ZERO_RST;
            value_out   <= CSF_ZERO_RST;
            value_valid <= 1'b0;
        end else begin
            value_valid <= st_reg == ST_FILT;
            if (st_reg == ST_FILT) begin
                value_out <= filt;
                yp_reg    <= filt;
                if (fmode == FM_PEAK) begin
                    if (ext_clr || !tv_reg || better || found) begin
                        trk_reg <= s_reg;
                    end
                    tv_reg   <= 1'b1;
                    held_reg <= held_now;
                    hc_reg   <= (hc_now != '0) ? hc_now - 1'b1 : '0;
                end
            end
        end
    end
endmodule

// file: rtl/csf_div.sv
// serial fixed-point divider, quotient = (num << F) / den
// assumes start only while idle; a zero divisor gives zero
`timescale 1ns/1ps
module csf_div #(
    parameter int W = 32,
    parameter int F = 16
) (
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          nrst,
    // request
    input  wire logic          start,
    input  wire logic [W-1:0]  num,
    input  wire logic [W-1:0]  den,
    // answer
    output      logic          done,
    output      logic [W-1:0]  quot
);
    localparam int DW = W + F;

    logic [DW-1:0] dvd_reg;
    logic [DW-1:0] q_reg;
    logic [W:0]    rem_reg;
    logic [W-1:0]  dsr_reg;
    logic          neg_reg;
    logic [6:0]    cnt_reg;
    logic          done_reg;
    logic [W:0]    rem_sh;
    logic [W-1:0]  num_abs;
    logic [W-1:0]  den_abs;

    assign num_abs = num[W-1] ? W'(-num) : num;
    assign den_abs = den[W-1] ? W'(-den) : den;
    assign rem_sh  = {rem_reg[W-1:0], dvd_reg[DW-1]};
    assign done    = done_reg;
    assign quot    = neg_reg ? W'(-q_reg[W-1:0]) : q_reg[W-1:0];

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dvd_reg  <= '0;
            q_reg    <= '0;
            rem_reg  <= '0;
            dsr_reg  <= '0;
            neg_reg  <= 1'b0;
            cnt_reg  <= 7'h00;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (start) begin
                dvd_reg <= {num_abs, F'(0)};
                q_reg   <= '0;
                rem_reg <= '0;
                dsr_reg <= den_abs;
                neg_reg <= num[W-1] ^ den[W-1];
                cnt_reg <= 7'(DW);
            end else if (cnt_reg != 7'h00) begin
                dvd_reg <= {dvd_reg[DW-2:0], 1'b0};
                if (dsr_reg != '0 && rem_sh >= {1'b0, dsr_reg}) begin
                    rem_reg <= rem_sh - {1'b0, dsr_reg};
                    q_reg   <= {q_reg[DW-2:0], 1'b1};
                end else begin
                    rem_reg <= rem_sh;
                    q_reg   <= {q_reg[DW-2:0], 1'b0};
                end
                cnt_reg <= cnt_reg - 7'h01;
                if (cnt_reg == 7'h01) begin
                    done_reg <= 1'b1;
                end
            end
        end
    end
endmodule

// file: rtl/csf_mul.sv
// fixed-point multiplier, product scaled back by the fraction width
// assumes operands small enough that the result fits the data width
`timescale 1ns/1ps
module csf_mul #(
    parameter int W = 32,
    parameter int F = 16
) (
    // operands
    input  wire logic signed [W-1:0] a,
    input  wire logic signed [W-1:0] b,
    // result
    output      logic signed [W-1:0] p
);
    logic signed [2*W-1:0] full;

    assign full = a * b;
    assign p    = full[W+F-1:F];
endmodule

// file: shared/csf_pkg.sv
// constants, register map and types of the channel scale-and-filter block
// assumes q16.16 signed samples and one 125 MHz clock
package csf_pkg;
    localparam int CSF_DW          = 32;
    localparam int CSF_FRAC        = 16;
    localparam int CSF_PT_MAX      = 20;
    localparam int CSF_PT_MIN      = 2;
    localparam int CSF_SAMPLE_US   = 100000;
    localparam int CSF_CLK_MHZ     = 125;
    localparam int CSF_TICK_CYCLES = CSF_SAMPLE_US * CSF_CLK_MHZ;

    // register byte offsets
    localparam logic [7:0] CSF_A_CTRL   = 8'h00;
    localparam logic [7:0] CSF_A_STATUS = 8'h04;
    localparam logic [7:0] CSF_A_LIN_X1 = 8'h08;
    localparam logic [7:0] CSF_A_LIN_Y1 = 8'h0c;
    localparam logic [7:0] CSF_A_LIN_X2 = 8'h10;
    localparam logic [7:0] CSF_A_LIN_Y2 = 8'h14;
    localparam logic [7:0] CSF_A_ADDEND = 8'h18;
    localparam logic [7:0] CSF_A_K      = 8'h1c;
    localparam logic [7:0] CSF_A_THR    = 8'h20;
    localparam logic [7:0] CSF_A_HOLD   = 8'h24;
    localparam logic [7:0] CSF_A_PT_SEL = 8'h28;
    localparam logic [7:0] CSF_A_PT_X   = 8'h2c;
    localparam logic [7:0] CSF_A_PT_Y   = 8'h30;
    localparam logic [7:0] CSF_A_CMD    = 8'h34;
    localparam logic [7:0] CSF_A_TP_SEL = 8'h38;
    localparam logic [7:0] CSF_A_TP_X   = 8'h3c;
    localparam logic [7:0] CSF_A_TP_Y   = 8'h40;
    localparam logic [7:0] CSF_A_TP_CNT = 8'h44;
    localparam logic [7:0] CSF_A_VALUE  = 8'h48;

    // field positions
    localparam int CSF_CTRL_SCALE = 0;
    localparam int CSF_CTRL_FILT  = 2;
    localparam int CSF_CTRL_VALLY = 4;
    localparam int CSF_CTRL_EXTR  = 5;
    localparam int CSF_CMD_ADD    = 0;
    localparam int CSF_CMD_DEL    = 1;
    localparam int CSF_CMD_IMP    = 2;
    localparam int CSF_CMD_EXP    = 3;
    localparam int CSF_ST_SEL     = 5;
    localparam int CSF_ST_BUSY    = 10;
    localparam int CSF_ST_HELD    = 11;

    // reset values
    localparam logic [31:0] CSF_ZERO_RST = 32'h0000_0000;
    localparam logic [31:0] CSF_ONE_RST  = 32'h0001_0000;
    localparam logic [4:0]  CSF_CNT_RST  = 5'h02;

    typedef enum logic [1:0] {
        SM_NONE = 2'b00,
        SM_LIN  = 2'b01,
        SM_OFF  = 2'b10,
        SM_CHAR = 2'b11
    } csf_scale_t;

    typedef enum logic [1:0] {
        FM_NONE   = 2'b00,
        FM_SMOOTH = 2'b01,
        FM_PEAK   = 2'b10,
        FM_RSVD   = 2'b11
    } csf_filt_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_DIV   = 2'b01,
        ST_SCALE = 2'b10,
        ST_FILT  = 2'b11
    } csf_state_t;
endpackage
